// File: core/tecp_top.v
// Timer with external clock synchronizer, prescaler and register slave
//
// Contract
// RULE1 - Sample prescaler output on phases two, four
// RULE2 - Unassigned prescaler: pin passes straight through
// RULE3 - Source holds pin two oscillator periods each
// RULE4 - Assigned prescaler divides pin, symmetric output
// RULE5 - Prescaled period four periods over ratio
// RULE6 - Increment only after synchronized edge seen
// RULE7 - Prescaler assignment changeable any time
// RULE8 - Software clears watchdog, timer, then writes rate
// RULE9 - Timer write clears prescaler when assigned
// RULE10 - Rates 000/001 need intermediate 111 step
// RULE11 - Watchdog to timer: clear first, then assign
// RULE12 - Bit four shared, open-drain, timer clock
// RULE13 - Port A inputs via Schmitt buffers
// RULE14 - Wrap sets overflow flag, gated interrupt
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`include "tecp_consts.vh"

module tecp_top (
  input  wire                  clk_sys_i,
  input  wire                  sys_rst_i,
  // Avalon-MM slave
  input  wire [9:0]            avs_address_i,
  input  wire                  avs_read_i,
  input  wire                  avs_write_i,
  input  wire [31:0]           avs_writedata_i,
  input  wire [3:0]            avs_byteenable_i,
  output reg  [31:0]           avs_readdata_o,
  output reg                   avs_waitrequest_o,
  // Port A pins
  input  wire [`TECP_PA_W-1:0] port_a_i,
  output reg  [`TECP_PA_W-1:0] port_a_o,
  output reg  [`TECP_PA_W-1:0] port_a_oe_n_o,
  // Watchdog hand-over
  input  wire                  watchdog_tick_i,
  input  wire                  watchdog_clear_i,
  output reg                   watchdog_tick_o,
  // Overflow interrupt
  output reg                   irq_o
);

  // Phase codes, one-hot
  localparam [3:0] PH_Q1 = 4'h1;
  localparam [3:0] PH_Q2 = 4'h2;
  localparam [3:0] PH_Q3 = 4'h4;
  localparam [3:0] PH_Q4 = 4'h8;

  // Phase state
  reg  [3:0]             phase_q;
  reg  [3:0]             phase_d;
  // Pin input stage
  reg  [`TECP_PA_W-1:0]  pin_q;
  // Registers
  reg  [7:0]             timer_count_q;
  reg  [7:0]             timer_count_d;
  reg  [`TECP_PA_W-1:0]  port_data_q;
  reg  [`TECP_PA_W-1:0]  port_dir_q;
  reg  [7:0]             irq_ctrl_q;
  reg  [7:0]             irq_ctrl_d;
  reg  [7:0]             opt_q;
  // Synchronizer state
  reg                    smp_q;
  reg                    smp_dly_q;
  // Bus handshake
  reg  [31:0]            rdata_d;
  reg                    acc_wr;

  wire                   wr_lane;
  reg                    hit_tmr;
  reg                    hit_pdat;
  reg                    hit_intc;
  reg                    hit_opt;
  reg                    hit_pdir;
  wire                   tmr_clk;
  wire                   wr_tmr;
  wire                   wr_intc;
  wire                   prescaler_assign_bit;
  wire                   cs_ext;
  wire                   pin_edge_src;
  wire                   instr_tick;
  wire                   psc_src;
  wire                   psc_clr;
  wire                   psc_out;
  wire                   at_sample;
  wire                   tmr_inc;
  wire                   tmr_wrap;
  wire                   tmr_psc_src;

  // Configuration fields
  assign prescaler_assign_bit    = opt_q[`TECP_OPT_PSA];
  assign cs_ext = opt_q[`TECP_OPT_CS];

  // Next phase: four phase clocks per instruction cycle
  always @* begin
    case (phase_q)
      PH_Q1: begin
        phase_d = PH_Q2;
      end
      PH_Q2: begin
        phase_d = PH_Q3;
      end
      PH_Q3: begin
        phase_d = PH_Q4;
      end
      PH_Q4: begin
        phase_d = PH_Q1;
      end
      default: begin
        phase_d = PH_Q1;
      end
    endcase
  end

  // Phase state register
  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase_q <= PH_Q1;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign instr_tick = (phase_q == PH_Q4);

  // Port pins captured through the hysteresis input stage
  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_q <= {`TECP_PA_W{1'b0}};
    end else begin
      pin_q <= port_a_i; // RULE13
    end
  end

  // Timer clock source: pin with edge polarity, or instruction cycle
  assign pin_edge_src = pin_q[`TECP_PA_TCK] ^ opt_q[`TECP_OPT_SE]; // RULE12
  assign tmr_psc_src  = cs_ext ? pin_edge_src : instr_tick;

  // Prescaler source follows its assignment
  assign psc_src = prescaler_assign_bit ? watchdog_tick_i : tmr_psc_src; // RULE7

  // Prescaler clears on timer write or on watchdog clear, per owner
  assign psc_clr = (wr_tmr & ~prescaler_assign_bit) | (watchdog_clear_i & prescaler_assign_bit); // RULE9

  // Prescaler shared between timer and watchdog; it always divides
  tecp_prescaler u_psc (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .src_i     (psc_src),
    .clr_i     (psc_clr),
    .bypass_i  (1'b0),
    .tap_i     (opt_q[`TECP_OPT_PS_HI:`TECP_OPT_PS_LO]),
    .out_o     (psc_out)
  );

  // Timer side takes its source directly while the watchdog owns the prescaler
  assign tmr_clk = prescaler_assign_bit ? tmr_psc_src : psc_out; // RULE2 RULE4

  // Sampling points within the instruction cycle
  assign at_sample = (phase_q == PH_Q2) | (phase_q == PH_Q4); // RULE1

  // Synchronizer: timer clock sampled on phases two and four
  // Resets high, the idle level of the reset-time source, so no false count
  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      smp_q     <= 1'b1;
      smp_dly_q <= 1'b1;
    end else begin
      if (at_sample) begin
        smp_q     <= tmr_clk; // RULE1 RULE2
        smp_dly_q <= smp_q;
      end
    end
  end

  // Increment only once the sampled edge is seen
  assign tmr_inc  = at_sample & smp_q & ~smp_dly_q; // RULE6
  assign tmr_wrap = tmr_inc & (timer_count_q == 8'hFF);

  // Bus decode on byte addresses, four per index
  always @* begin
    hit_tmr  = 1'b0;
    hit_pdat = 1'b0;
    hit_intc = 1'b0;
    hit_opt  = 1'b0;
    hit_pdir = 1'b0;
    if (avs_address_i == {`TECP_IDX_TMR, 2'h0}) begin
      hit_tmr = 1'b1;
    end else if (avs_address_i == {`TECP_IDX_PDAT, 2'h0}) begin
      hit_pdat = 1'b1;
    end else if (avs_address_i == {`TECP_IDX_INTC, 2'h0}) begin
      hit_intc = 1'b1;
    end else if (avs_address_i == {`TECP_IDX_OPT, 2'h0}) begin
      hit_opt = 1'b1;
    end else if (avs_address_i == {`TECP_IDX_PDIR, 2'h0}) begin
      hit_pdir = 1'b1;
    end
  end

  // Write takes effect on the edge where waitrequest is low
  always @* begin
    acc_wr = avs_write_i & ~avs_read_i & ~avs_waitrequest_o;
  end

  assign wr_lane = acc_wr & avs_byteenable_i[0];
  assign wr_tmr  = wr_lane & hit_tmr;
  assign wr_intc = wr_lane & hit_intc;

  // Timer count: software write beats increment
  always @* begin
    timer_count_d = timer_count_q;
    if (wr_tmr) begin
      timer_count_d = avs_writedata_i[7:0];
    end else if (tmr_inc) begin
      timer_count_d = timer_count_q + 8'h01; // RULE6
    end
  end

  // Interrupt control: overflow set wins over software clear
  always @* begin
    irq_ctrl_d = irq_ctrl_q;
    if (wr_intc) begin
      irq_ctrl_d = avs_writedata_i[7:0];
    end
    if (tmr_wrap) begin
      irq_ctrl_d[`TECP_INTC_OVF] = 1'b1; // RULE14
    end
  end

  // Register file
  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer_count_q <= `TECP_RST_TMR;
      port_data_q   <= `TECP_RST_PDAT;
      port_dir_q    <= `TECP_RST_PDIR;
      irq_ctrl_q    <= `TECP_RST_INTC;
      opt_q         <= `TECP_RST_OPT;
    end else begin
      timer_count_q <= timer_count_d;
      irq_ctrl_q    <= irq_ctrl_d;
      if (wr_lane && hit_pdat) begin
        port_data_q <= avs_writedata_i[`TECP_PA_W-1:0];
      end
      if (wr_lane && hit_pdir) begin
        port_dir_q <= avs_writedata_i[`TECP_PA_W-1:0];
      end
      if (wr_lane && hit_opt) begin
        opt_q <= avs_writedata_i[7:0]; // RULE7
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    rdata_d = 32'h0000_0000;
    if (hit_tmr) begin
      rdata_d[7:0] = timer_count_q;
    end else if (hit_pdat) begin
      rdata_d[`TECP_PA_W-1:0] = pin_q;
    end else if (hit_intc) begin
      rdata_d[7:0] = irq_ctrl_q;
    end else if (hit_opt) begin
      rdata_d[7:0] = opt_q;
    end else if (hit_pdir) begin
      rdata_d[`TECP_PA_W-1:0] = port_dir_q;
    end
  end

  // One wait cycle, then a single accept cycle
  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end else begin
      if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
        avs_waitrequest_o <= 1'b0;
        if (avs_read_i) begin
          avs_readdata_o <= rdata_d;
        end
      end else begin
        avs_waitrequest_o <= 1'b1;
      end
    end
  end

  // Pin drivers: bit four only pulls low, others push-pull
  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      port_a_o      <= {`TECP_PA_W{1'b0}};
      port_a_oe_n_o <= {`TECP_PA_W{1'b1}};
    end else begin
      port_a_o <= port_data_q & ~(5'h01 << `TECP_PA_TCK); // RULE12
      port_a_oe_n_o <= port_dir_q |
        ((5'h01 << `TECP_PA_TCK) & port_data_q); // RULE12
    end
  end

  // Watchdog tick and overflow interrupt
  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      watchdog_tick_o <= 1'b0;
      irq_o           <= 1'b0;
    end else begin
      watchdog_tick_o <= prescaler_assign_bit ? psc_out : watchdog_tick_i; // RULE7
      irq_o <= irq_ctrl_q[`TECP_INTC_GIE] & irq_ctrl_q[`TECP_INTC_OVIE] &
               irq_ctrl_q[`TECP_INTC_OVF]; // RULE14
    end
  end

endmodule // tecp_top

// File: core/tecp_consts.vh
// Constants for the timer with external clock prescaler
`ifndef TECP_CONSTS_VH
`define TECP_CONSTS_VH

// Register indexes; byte address is four times the index
`define TECP_IDX_TMR      8'h01
`define TECP_IDX_PDAT     8'h05
`define TECP_IDX_INTC     8'h0B
`define TECP_IDX_OPT      8'h81
`define TECP_IDX_PDIR     8'h85

// Reset values
`define TECP_RST_TMR      8'h00
`define TECP_RST_PDAT     5'h00
`define TECP_RST_INTC     8'h00
`define TECP_RST_OPT      8'hFF
`define TECP_RST_PDIR     5'h1F

// Configuration register fields
`define TECP_OPT_CS       5
`define TECP_OPT_SE       4
`define TECP_OPT_PSA      3
`define TECP_OPT_PS_HI    2
`define TECP_OPT_PS_LO    0

// Interrupt control fields
`define TECP_INTC_GIE     7
`define TECP_INTC_OVIE    5
`define TECP_INTC_OVF     2

// Port A layout
`define TECP_PA_W         5
`define TECP_PA_TCK       4

// Timing: one oscillator period per system clock
`define TECP_CLK_NS       100
`define TECP_TOSC_NS      100
`define TECP_TOSC_CYC     (`TECP_TOSC_NS / `TECP_CLK_NS)
`define TECP_PULSE_TOSC   2
`define TECP_PULSE_CYC    (`TECP_PULSE_TOSC * `TECP_TOSC_CYC)

// Prescaler width
`define TECP_PSC_W        8

`endif

// File: core/tecp_prescaler.v
// Prescaler counter with selectable tap and bypass
`timescale 1ns/1ps
`include "tecp_consts.vh"

module tecp_prescaler (
  input  wire       clk_sys_i,
  input  wire       sys_rst_i,
  input  wire       src_i,
  input  wire       clr_i,
  input  wire       bypass_i,
  input  wire [2:0] tap_i,
  output wire       out_o
);

  reg                     src_q;
  reg  [`TECP_PSC_W-1:0]  cnt_q;
  reg  [`TECP_PSC_W-1:0]  cnt_d;
  wire                    src_rise;

  assign src_rise = src_i & ~src_q;

  // Count rising source edges; clear wins
  always @* begin
    cnt_d = cnt_q;
    if (clr_i) begin
      cnt_d = {`TECP_PSC_W{1'b0}};
    end else if (src_rise) begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      src_q <= 1'b0;
      cnt_q <= {`TECP_PSC_W{1'b0}};
    end else begin
      src_q <= src_i;
      cnt_q <= cnt_d;
    end
  end

  // Tap bit gives a symmetrical divided square wave
  assign out_o = bypass_i ? src_i : cnt_q[tap_i]; // RULE4

endmodule // tecp_prescaler

// File: sim/tecp_clk_src.sv
// External clock source model for the timer pin
`timescale 1ns/1ps
module tecp_clk_src (
  input  logic clk_sys_i,
  output logic pin_o
);
  initial pin_o = 1'b0;

  // Bursts of n pulses, level lengths in clocks; idles low between bursts
  task automatic burst(input int n, input int hi, input int lo);
    repeat (n) begin
      pin_o <= 1'b1;
      repeat (hi) @(posedge clk_sys_i);
      pin_o <= 1'b0;
      repeat (lo) @(posedge clk_sys_i);
    end
  endtask
endmodule // tecp_clk_src

// File: sim/tecp_top_chk.sv
// Port-level assertions for the timer block
`timescale 1ns/1ps
module tecp_top_chk (
  input logic        clk_sys_i,
  input logic        sys_rst_i,
  input logic [9:0]  avs_address_i,
  input logic        avs_read_i,
  input logic        avs_write_i,
  input logic [31:0] avs_writedata_i,
  input logic [3:0]  avs_byteenable_i,
  input logic [31:0] avs_readdata_o,
  input logic        avs_waitrequest_o,
  input logic [4:0]  port_a_o,
  input logic [4:0]  port_a_oe_n_o,
  input logic        watchdog_tick_i,
  input logic        watchdog_tick_o,
  input logic        irq_o
);
  logic [7:0] opt_q;
  logic [7:0] intc_q;
  logic       dir4_q;
  logic       dat4_q;
  wire        wr_ok = avs_write_i && !avs_read_i && !avs_waitrequest_o && avs_byteenable_i[0];
  wire        od_on = !dir4_q && !dat4_q;

  // Shadow copies of the written registers
  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      opt_q  <= 8'hff;
      intc_q <= 8'h00;
      dir4_q <= 1'b1;
      dat4_q <= 1'b0;
    end else if (wr_ok) begin
      if (avs_address_i == 10'h204) opt_q <= avs_writedata_i[7:0];
      if (avs_address_i == 10'h02c) intc_q <= avs_writedata_i[7:0];
      if (avs_address_i == 10'h214) dir4_q <= avs_writedata_i[4];
      if (avs_address_i == 10'h014) dat4_q <= avs_writedata_i[4];
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  // Bus handshake, refusals, pin, hand-over and interrupt relations
  a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("request not answered in one cycle");
  a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_wait_idle: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
    else $error("answer without request");
  a_rd_unmapped: assert property (avs_read_i && avs_waitrequest_o && avs_address_i == 10'h3fc
    |=> avs_readdata_o == 32'h0000_0000) else $error("unmapped read not zero");
  a_od_low: assert property (port_a_o[4] == 1'b0) else $error("bit four driven high");
  a_od_drive: assert property (!port_a_oe_n_o[4] |-> od_on || $past(od_on))
    else $error("bit four driven without low data");
  a_wdog_pass: assert property (!opt_q[3] && !$past(opt_q[3])
    |-> watchdog_tick_o == $past(watchdog_tick_i)) else $error("tick not passed");
  a_irq_gated: assert property (irq_o |-> (intc_q[7] && intc_q[5])
    || ($past(intc_q[7]) && $past(intc_q[5]))) else $error("interrupt while disabled");

  c_write: cover property (wr_ok);
  c_irq: cover property ($rose(irq_o));
  c_wd_tick: cover property (opt_q[3] && $rose(watchdog_tick_o));
endmodule // tecp_top_chk

bind tecp_top tecp_top_chk u_chk (.*);

// File: sim/test_timer_ext_clock_prescaler.sv
// Self-checking bench for the timer with external clock prescaler
`timescale 1ns/1ps
module test_timer_ext_clock_prescaler;
  logic        clk_sys_i = 0, sys_rst_i = 1, avs_read_i = 0, avs_write_i = 0;
  logic        watchdog_tick_i = 0, watchdog_clear_i = 0, wd_prev = 0;
  logic [9:0]  avs_address_i = 0;
  logic [31:0] avs_writedata_i = 0, avs_readdata_o;
  logic [3:0]  avs_byteenable_i = 0, pa_lo = 0;
  logic [4:0]  port_a_i, port_a_o, port_a_oe_n_o;
  logic        avs_waitrequest_o, watchdog_tick_o, irq_o, pin;
  logic [7:0]  d;
  int          n_errors = 0, check_count = 0, tmr, psc, ratio, rises = 0;

  tecp_top DUT (.*);
  tecp_clk_src src (.clk_sys_i, .pin_o(pin));

  // Clock, open-drain wire level, watchdog tick edge count
  always #50 clk_sys_i = !clk_sys_i;
  assign port_a_i = {pin & (port_a_oe_n_o[4] | port_a_o[4]), pa_lo};
  always @(posedge clk_sys_i) begin
    wd_prev <= watchdog_tick_o;
    if (watchdog_tick_o && !wd_prev) rises <= rises + 1;
  end

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", w, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] i, v, input logic [3:0] be);
    int t;
    @(posedge clk_sys_i);
    avs_address_i <= {i, 2'b00};
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= {24'h0, v};
    avs_byteenable_i <= be;
    for (t = 0; t < 20; t++) begin
      @(posedge clk_sys_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    d = avs_readdata_o[7:0];
    avs_write_i <= 0;
    avs_read_i <= 0;
    if (t == 20) begin
      n_errors++;
      wrap_up;
    end
  endtask

  task automatic wr(input logic [7:0] i, v);
    bus(1, i, v, 4'h1);
  endtask

  task automatic rchk(input string w, input logic [7:0] i, e);
    bus(0, i, 8'h00, 4'h1);
    chk(w, e, d);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // Pin pulses, model update, then timer readback
  task automatic run(input int n, hi, lo);
    src.burst(n, hi, lo);
    repeat (n) if (ratio == 1) tmr++;
    else begin
      psc++;
      if (psc % ratio == ratio / 2) tmr++;
    end
    wait_n(8);
    rchk("timer", 8'h01, tmr[7:0]);
  endtask

  task automatic setup(input logic [7:0] cfg);
    wr(8'h81, cfg);
    wait_n(8);
    wr(8'h01, 8'h00);
    tmr = 0;
    psc = 0;
  endtask

  task automatic wd_clr;
    watchdog_clear_i <= 1;
    @(posedge clk_sys_i);
    watchdog_clear_i <= 0;
  endtask

  // Main sequence
  initial begin
    d = 8'($urandom(2));
    wait_n(4);
    sys_rst_i <= 0;
    rchk("config", 8'h81, 8'hff);
    rchk("direction", 8'h85, 8'h1f);
    rchk("intc", 8'h0b, 8'h00);
    rchk("timer", 8'h01, 8'h00);
    wr(8'hff, 8'h12);
    rchk("unmapped", 8'hff, 8'h00);
    bus(1, 8'h01, 8'h5a, 4'h1);
    bus(1, 8'h01, 8'ha5, 4'he);
    rchk("timer", 8'h01, 8'h5a);
    $display("test registers done");
    ratio = 1;
    for (int s = 0; s < 2; s++) begin
      setup({3'b001, s[0], 4'hf});
      run(5 + $urandom % 6, 2, 2);
    end
    $display("test bypass done");
    for (int r = 0; r < 8; r++) begin
      ratio = 2 << r;
      setup({3'b001, r[0], 1'b0, r[2:0]});
      run(ratio * (1 + $urandom % 2), 1, 1);
      run(ratio / 2, 1, 1);
      wr(8'h01, 8'h00);
      tmr = 0;
      psc = 0;
      run(ratio / 2, 1, 1);
    end
    $display("test prescaler done");
    ratio = 1;
    setup(8'h2f);
    wr(8'h0b, 8'ha0);
    wr(8'h01, 8'hfe);
    tmr = 254;
    run(2, 2, 2);
    rchk("intc", 8'h0b, 8'ha4);
    chk("irq", 1, irq_o);
    wr(8'h0b, 8'h24);
    wait_n(2);
    chk("irq", 0, irq_o);
    wr(8'h0b, 8'ha0);
    rchk("intc", 8'h0b, 8'ha0);
    $display("test overflow done");
    setup(8'h0f);
    wait_n(40);
    bus(0, 8'h01, 8'h00, 4'h1);
    check_count++;
    if (d !== 8'h0a && d !== 8'h0b) begin
      n_errors++;
      $display("unexpected internal count: expected 0a or 0b, seen %h", d);
    end
    $display("test internal clock done");
    wd_clr;
    wr(8'h01, 8'h00);
    wr(8'h81, 8'h2f);
    wd_clr;
    wr(8'h81, 8'h28);
    rises = 0;
    repeat (4) begin
      watchdog_tick_i <= 1;
      wait_n(2);
      watchdog_tick_i <= 0;
      wait_n(2);
    end
    wait_n(4);
    chk("watchdog rises", 2, rises[7:0]);
    wd_clr;
    wr(8'h81, 8'h27);
    watchdog_tick_i <= 1;
    wait_n(3);
    chk("watchdog pass", 1, watchdog_tick_o);
    $display("test hand-over done");
    pa_lo <= 4'($urandom);
    wr(8'h85, 8'h00);
    wr(8'h05, 8'h00);
    wait_n(2);
    chk("oe_n", 8'h00, port_a_oe_n_o);
    rchk("pins", 8'h05, {4'h0, pa_lo});
    wr(8'h05, 8'h1f);
    wait_n(2);
    chk("oe_n", 8'h10, port_a_oe_n_o);
    chk("pin out", 8'h0f, port_a_o);
    $display("test port done");
    wrap_up;
  end
endmodule // test_timer_ext_clock_prescaler
